// [usr_engine_model.sv]
/* Transmit engine model: takes held chars and pending breaks.
   Assumes the bench may stall it to keep the holding register full. */
`timescale 1ns/1ps
`default_nettype none
module usr_engine_model (
  input  wire logic ref_clk,       // Clock
  input  wire logic sys_rst,       // Sync reset
  input  wire logic stall,         // Hold off the engine
  input  wire logic txCharPending, // Holding full
  input  wire logic beginBreakReq, // Break pending
  output logic      txShiftLoad,   // Char taken
  output logic      txShiftBusy,   // Shifting
  output logic      breakStarted   // Break begun
);
  logic [3:0] cnt;
  // Load only once a char is held, then shift for eight cycles
  always_ff @(posedge ref_clk) begin
    txShiftLoad <= 1'b0;
    breakStarted <= 1'b0;
    if (sys_rst) begin
      cnt <= 4'h0;
    end else if (cnt != 4'h0) begin
      cnt <= cnt - 4'h1;
    end else if (txCharPending && !stall && !txShiftLoad) begin
      txShiftLoad <= 1'b1;
      cnt <= 4'h8;
    end else if (beginBreakReq && !stall && !breakStarted) begin
      breakStarted <= 1'b1;
    end
  end
  assign txShiftBusy = cnt != 4'h0;
endmodule
`default_nettype wire

// [usr_pkg.sv]
/*
  Constants for the serial channel status, mask and holding block:
  APB offsets, bit positions of the shared status map, command bits
  and field widths.
  Assumes a 32-bit APB with word-aligned registers.
*/
// How it works
// - Disable write ones clear mask bits
// - Mask read shows enabled sources
// - Shared bit map, bits 0-13, 16-19
// - Status bits 20-23 mirror modem pins
// - Receive ready: set on char, clear
// - Receive ready returns on re-enable
// - Transmit ready low: full, break, disabled
// - Transmit ready high at enable
// - Break flag sticky until error clear
// - Overrun flag sticky until error clear
// - Framing flag sticky until error clear
// - Parity flag sticky until error clear
// - Timeout flag, zero when value zero
// - Transmit empty low while busy, disabled
// - Retry flag sticky until retry clear
// - DMA end flags follow, no latch
// - DMA buffer flags follow directly
// - Refusal flag sticky until refusal clear
// - Modem change flags, clear on read
// - Receive character in bits 0-8
// - Error clear clears four flags together
// - Enable write ones set mask bits
`default_nettype none
package usr_pkg;

  // Register byte offsets
  localparam logic [7:0] OFS_COMMAND   = 8'h00;
  localparam logic [7:0] OFS_IRQ_EN    = 8'h08;
  localparam logic [7:0] OFS_IRQ_DIS   = 8'h0c;
  localparam logic [7:0] OFS_IRQ_MASK  = 8'h10;
  localparam logic [7:0] OFS_STATUS    = 8'h14;
  localparam logic [7:0] OFS_RX_HOLD   = 8'h18;
  localparam logic [7:0] OFS_TX_HOLD   = 8'h1c;
  localparam logic [7:0] OFS_TIMEOUT   = 8'h24;
  localparam logic [7:0] OFS_LINK      = 8'h28;

  // Status / mask bit positions
  localparam int BIT_RX_AVAIL    = 0;
  localparam int BIT_TX_FREE     = 1;
  localparam int BIT_BREAK       = 2;
  localparam int BIT_RX_DMA_END  = 3;
  localparam int BIT_TX_DMA_END  = 4;
  localparam int BIT_OVERRUN     = 5;
  localparam int BIT_FRAMING     = 6;
  localparam int BIT_PARITY      = 7;
  localparam int BIT_TIMEOUT     = 8;
  localparam int BIT_TX_DRAINED  = 9;
  localparam int BIT_RETRY       = 10;
  localparam int BIT_TX_BUF_DRN  = 11;
  localparam int BIT_RX_BUF_FULL = 12;
  localparam int BIT_REFUSAL     = 13;
  localparam int BIT_CHG_LO      = 16;
  localparam int BIT_LVL_LO      = 20;
  localparam int MODEM_PINS      = 4;
  localparam int IRQ_BITS        = 20;

  // Bits that exist in the mask register
  localparam logic [31:0] MASK_VALID  = 32'h000f3fff;
  localparam logic [31:0] MASK_RESET  = 32'h00000000;

  // Command register bits
  localparam int CMD_RX_EN       = 4;
  localparam int CMD_RX_DIS      = 5;
  localparam int CMD_TX_EN       = 6;
  localparam int CMD_TX_DIS      = 7;
  localparam int CMD_CLR_ERR     = 8;
  localparam int CMD_BEGIN_BRK   = 9;
  localparam int CMD_START_TMO   = 11;
  localparam int CMD_CLR_RETRY   = 13;
  localparam int CMD_CLR_REFUSAL = 14;

  // Field widths
  localparam int CHAR_W          = 9;
  localparam int TMO_W           = 16;
  localparam logic [TMO_W-1:0] TMO_RESET = 16'h0000;

endpackage
`default_nettype wire

// [usr_status_regs.sv]
/*
  Status, interrupt-mask and character-holding registers of a serial
  transceiver, reached over APB (zero wait states).
  Assumes the receive/transmit engines, time-out counter and DMA
  channels run on ref_clk and drive the event and level inputs; the
  four modem pins are asynchronous and are synchronised here.
*/
// The address map and register access over APB are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module usr_status_regs (
  input  wire logic                     ref_clk,          // 40 MHz clock
  input  wire logic                     sys_rst,          // Sync reset, high
  // APB slave
  input  wire logic                     psel,             // Select
  input  wire logic                     penable,          // Access phase
  input  wire logic                     pwrite,           // Write when high
  input  wire logic [7:0]               paddr,            // Byte address
  input  wire logic [31:0]              pwdata,           // Write data
  output logic                          pready,           // Always ready
  output logic                          pslverr,          // Unmapped or wrong-direction access
  output logic      [31:0]              prdata,           // Read data
  // Receiver engine
  input  wire logic                     rxCharDone,       // Char complete pulse
  input  wire logic [usr_pkg::CHAR_W-1:0] rxCharField,    // Received char
  input  wire logic                     overrunEvt,       // Overrun pulse
  input  wire logic                     framingEvt,       // Stop bit low pulse
  input  wire logic                     parityEvt,        // Parity fail pulse
  input  wire logic                     breakEvt,         // Break or break end
  input  wire logic                     timeoutEvt,       // Time-out expiry
  input  wire logic                     retryLimitEvt,    // Max repetitions
  input  wire logic                     refusalEvt,       // Non-acknowledge
  // Transmitter engine
  input  wire logic                     txShiftLoad,      // Holding char taken
  input  wire logic                     txShiftBusy,      // Shift reg occupied
  input  wire logic                     breakStarted,     // Break now sending
  output logic      [usr_pkg::CHAR_W-1:0] txCharField,    // Char to send
  output logic                          txCharPending,    // Holding reg full
  output logic                          beginBreakReq,    // Break pending
  output logic                          rxEnabled,        // Receiver on
  output logic                          txEnabled,        // Transmitter on
  output logic                          startTimeoutCmd,  // One-cycle pulse
  output logic      [usr_pkg::TMO_W-1:0] timeoutValue,    // Time-out setting
  // DMA channel levels
  input  wire logic                     rxDmaEnd,         // Rx end of transfer
  input  wire logic                     txDmaEnd,         // Tx end of transfer
  input  wire logic                     txDmaBufferDrained, // Tx buffer empty
  input  wire logic                     rxDmaBufferFull,  // Rx buffer full
  // Modem pins (asynchronous)
  input  wire logic [usr_pkg::MODEM_PINS-1:0] modemPins,  // Bell,setrdy,line,clr
  output logic                          irq               // Interrupt request
);

  // APB phase decode
  logic        setupPhase;
  logic        accessPhase;
  logic        decodeHit;
  logic        writeOk;
  logic [31:0] readMux;
  logic [31:0] statusWord;
  logic [31:0] irqMask;
  logic [31:0] cmdWord;
  logic        cmdWrite;

  assign setupPhase  = psel & ~penable;
  assign accessPhase = psel & penable;
  assign pready      = 1'b1;
  assign cmdWrite    = accessPhase & pwrite & (paddr == usr_pkg::OFS_COMMAND);
  assign cmdWord     = cmdWrite ? pwdata : 32'h00000000;

  // Modem pin synchroniser and change detect
  logic [usr_pkg::MODEM_PINS-1:0] modemMeta;
  logic [usr_pkg::MODEM_PINS-1:0] modemSync;
  logic [usr_pkg::MODEM_PINS-1:0] modemPrev;
  logic [usr_pkg::MODEM_PINS-1:0] modemChange;
  logic [2:0]                     modemPrimed;

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      modemMeta   <= 4'h0;
      modemSync   <= 4'h0;
      modemPrev   <= 4'h0;
      modemPrimed <= 3'h0;
    end else begin
      modemMeta   <= modemPins;
      modemSync   <= modemMeta;
      modemPrev   <= modemSync;
      modemPrimed <= {modemPrimed[1:0], 1'b1};
    end
  end

  // No change reported until sync and history both hold pin levels,
  // so a pin idling high at reset does not raise a false change
  assign modemChange = (modemSync ^ modemPrev) & {usr_pkg::MODEM_PINS{modemPrimed[2]}};

  // Receiver and transmitter enables from commands
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      rxEnabled <= 1'b0;
      txEnabled <= 1'b0;
    end else begin
      if (cmdWord[usr_pkg::CMD_RX_DIS]) begin
        rxEnabled <= 1'b0;
      end else if (cmdWord[usr_pkg::CMD_RX_EN]) begin
        rxEnabled <= 1'b1;
      end
      if (cmdWord[usr_pkg::CMD_TX_DIS]) begin
        txEnabled <= 1'b0;
      end else if (cmdWord[usr_pkg::CMD_TX_EN]) begin
        txEnabled <= 1'b1;
      end
    end
  end

  // Received character store and availability
  logic                       rxAvail;
  logic [usr_pkg::CHAR_W-1:0] rxChar;
  logic                       rxRead;

  assign rxRead = accessPhase & ~pwrite & (paddr == usr_pkg::OFS_RX_HOLD);

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      rxAvail <= 1'b0;
      rxChar  <= '0;
    end else begin
      if (rxCharDone) begin
        rxChar  <= rxCharField;
        rxAvail <= 1'b1;                              // set wins
      end else if (rxRead) begin
        rxAvail <= 1'b0;
      end
    end
  end

  // Transmit holding register and break request
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      txCharField   <= '0;
      txCharPending <= 1'b0;
      beginBreakReq <= 1'b0;
    end else begin
      if (accessPhase & pwrite & (paddr == usr_pkg::OFS_TX_HOLD)) begin
        txCharField   <= pwdata[usr_pkg::CHAR_W-1:0];
        txCharPending <= 1'b1;
      end else if (txShiftLoad) begin
        txCharPending <= 1'b0;
      end
      if (cmdWord[usr_pkg::CMD_BEGIN_BRK]) begin
        beginBreakReq <= 1'b1;
      end else if (breakStarted) begin
        beginBreakReq <= 1'b0;
      end
    end
  end

  // Time-out value and start command
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      timeoutValue    <= usr_pkg::TMO_RESET;
      startTimeoutCmd <= 1'b0;
    end else begin
      startTimeoutCmd <= cmdWord[usr_pkg::CMD_START_TMO];
      if (accessPhase & pwrite & (paddr == usr_pkg::OFS_TIMEOUT)) begin
        timeoutValue <= pwdata[usr_pkg::TMO_W-1:0];
      end
    end
  end

  // Sticky error flags; an event in the clear cycle wins
  logic breakFlag;
  logic overrunFlag;
  logic framingFlag;
  logic parityFlag;
  logic timeoutFlag;
  logic retryFlag;
  logic refusalFlag;
  logic clrErr;

  assign clrErr = cmdWord[usr_pkg::CMD_CLR_ERR];

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      breakFlag   <= 1'b0;
      overrunFlag <= 1'b0;
      framingFlag <= 1'b0;
      parityFlag  <= 1'b0;
    end else begin
      breakFlag   <= breakEvt   | (breakFlag   & ~clrErr);
      overrunFlag <= overrunEvt | (overrunFlag & ~clrErr);
      framingFlag <= framingEvt | (framingFlag & ~clrErr);
      parityFlag  <= parityEvt  | (parityFlag  & ~clrErr);
    end
  end

  // Time-out, retry and refusal flags
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      timeoutFlag <= 1'b0;
      retryFlag   <= 1'b0;
      refusalFlag <= 1'b0;
    end else begin
      if (timeoutValue == usr_pkg::TMO_RESET) begin
        timeoutFlag <= 1'b0;
      end else begin
        timeoutFlag <= timeoutEvt |
                       (timeoutFlag & ~cmdWord[usr_pkg::CMD_START_TMO]);
      end
      retryFlag   <= retryLimitEvt |
                     (retryFlag & ~cmdWord[usr_pkg::CMD_CLR_RETRY]);
      refusalFlag <= refusalEvt |
                     (refusalFlag & ~cmdWord[usr_pkg::CMD_CLR_REFUSAL]);
    end
  end

  // Modem change flags, cleared only for bits the read returned
  logic [usr_pkg::MODEM_PINS-1:0] changeFlag;
  logic [usr_pkg::MODEM_PINS-1:0] changeClr;
  logic                           statusRead;

  assign statusRead = accessPhase & ~pwrite & (paddr == usr_pkg::OFS_STATUS);
  assign changeClr  = statusRead ?
                      prdata[usr_pkg::BIT_CHG_LO +: usr_pkg::MODEM_PINS] : 4'h0;

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      changeFlag <= 4'h0;
    end else begin
      changeFlag <= modemChange | (changeFlag & ~changeClr);
    end
  end

  // Channel status word assembly
  always_comb begin
    statusWord = 32'h00000000;
    statusWord[usr_pkg::BIT_RX_AVAIL]    = rxAvail & rxEnabled;
    statusWord[usr_pkg::BIT_TX_FREE]     = txEnabled & ~txCharPending &
                                           ~beginBreakReq;
    statusWord[usr_pkg::BIT_BREAK]       = breakFlag;
    statusWord[usr_pkg::BIT_RX_DMA_END]  = rxDmaEnd;
    statusWord[usr_pkg::BIT_TX_DMA_END]  = txDmaEnd;
    statusWord[usr_pkg::BIT_OVERRUN]     = overrunFlag;
    statusWord[usr_pkg::BIT_FRAMING]     = framingFlag;
    statusWord[usr_pkg::BIT_PARITY]      = parityFlag;
    statusWord[usr_pkg::BIT_TIMEOUT]     = timeoutFlag;
    statusWord[usr_pkg::BIT_TX_DRAINED]  = txEnabled & ~txCharPending &
                                           ~txShiftBusy;
    statusWord[usr_pkg::BIT_RETRY]       = retryFlag;
    statusWord[usr_pkg::BIT_TX_BUF_DRN]  = txDmaBufferDrained;
    statusWord[usr_pkg::BIT_RX_BUF_FULL] = rxDmaBufferFull;
    statusWord[usr_pkg::BIT_REFUSAL]     = refusalFlag;
    statusWord[usr_pkg::BIT_CHG_LO +: usr_pkg::MODEM_PINS] = changeFlag;
    statusWord[usr_pkg::BIT_LVL_LO +: usr_pkg::MODEM_PINS] = modemSync;
  end

  // Interrupt mask: enable sets, disable clears, reserved stay zero
  logic [31:0] maskSet;
  logic [31:0] maskClr;

  assign maskSet = (accessPhase & pwrite & (paddr == usr_pkg::OFS_IRQ_EN)) ?
                   pwdata : 32'h00000000;
  assign maskClr = (accessPhase & pwrite & (paddr == usr_pkg::OFS_IRQ_DIS)) ?
                   pwdata : 32'h00000000;

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      irqMask <= usr_pkg::MASK_RESET;
    end else begin
      irqMask <= ((irqMask | maskSet) & ~maskClr) & usr_pkg::MASK_VALID;
    end
  end

  // Interrupt output
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(statusWord[usr_pkg::IRQ_BITS-1:0] & irqMask[usr_pkg::IRQ_BITS-1:0]);
    end
  end

  // Address decode for reads and legal writes
  always_comb begin
    readMux   = 32'h00000000;
    decodeHit = 1'b1;
    writeOk   = 1'b0;
    unique case (paddr)
      usr_pkg::OFS_COMMAND:  writeOk = 1'b1;
      usr_pkg::OFS_IRQ_EN:   writeOk = 1'b1;
      usr_pkg::OFS_IRQ_DIS:  writeOk = 1'b1;
      usr_pkg::OFS_TX_HOLD:  writeOk = 1'b1;
      usr_pkg::OFS_IRQ_MASK: readMux = irqMask;
      usr_pkg::OFS_STATUS:   readMux = statusWord;
      usr_pkg::OFS_RX_HOLD:  readMux[usr_pkg::CHAR_W-1:0] = rxChar;
      usr_pkg::OFS_TIMEOUT: begin
        readMux[usr_pkg::TMO_W-1:0] = timeoutValue;
        writeOk = 1'b1;
      end
      usr_pkg::OFS_LINK: begin
        readMux[0] = rxEnabled;
        readMux[1] = txEnabled;
      end
      default: decodeHit = 1'b0;
    endcase
  end

  // Read data captured in the setup cycle; error in the access cycle
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      prdata <= 32'h00000000;
    end else if (setupPhase) begin
      prdata <= pwrite ? 32'h00000000 : readMux;
    end
  end

  always_comb begin
    if (pwrite) begin
      pslverr = accessPhase & ~writeOk;
    end else begin
      pslverr = accessPhase & (~decodeHit | writeOk & (paddr != usr_pkg::OFS_TIMEOUT));
    end
  end

endmodule
`default_nettype wire

// [usr_status_regs_bench.sv]
/* Self-checking bench for the status block, APB master and engine model.
   Assumes a 40 MHz clock and a synchronous high reset. */
`timescale 1ns/1ps
`default_nettype none
bind usr_status_regs usr_status_regs_properties i_chk (.ref_clk(ref_clk), .sys_rst(sys_rst),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .rxDmaEnd(rxDmaEnd), .txCharPending(txCharPending),
  .txCharField(txCharField), .beginBreakReq(beginBreakReq), .txEnabled(txEnabled),
  .startTimeoutCmd(startTimeoutCmd), .irq(irq));
module usr_status_regs_bench;
  logic ref_clk = 0, sys_rst = 1, psel = 0, penable = 0, pwrite = 0, stall = 0, err;
  logic [7:0] paddr = 8'h00, evts = 8'h00;
  logic [31:0] pwdata = 32'h0, rd, r, e;
  logic [8:0] rxChar = 9'h000, txCharField;
  logic [3:0] dmaLv = 4'h0, pins = 4'h0, np;
  logic pready, pslverr, txCharPending, beginBreakReq, txEnabled, startTimeoutCmd, irq;
  logic txShiftLoad, txShiftBusy, breakStarted;
  logic [31:0] prdata;
  int seed, mismatches = 0, nTests = 0, n;
  int bitOf[7] = '{5, 6, 7, 2, 8, 10, 13};
  int clrOf[7] = '{8, 8, 8, 8, 11, 13, 14};
  always #12.5 ref_clk = ~ref_clk;
  usr_status_regs i_usr_status_regs (.ref_clk(ref_clk), .sys_rst(sys_rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .pslverr(pslverr), .prdata(prdata), .rxCharDone(evts[7]), .rxCharField(rxChar),
    .overrunEvt(evts[0]), .framingEvt(evts[1]), .parityEvt(evts[2]), .breakEvt(evts[3]),
    .timeoutEvt(evts[4]), .retryLimitEvt(evts[5]), .refusalEvt(evts[6]),
    .txShiftLoad(txShiftLoad), .txShiftBusy(txShiftBusy), .breakStarted(breakStarted),
    .txCharField(txCharField), .txCharPending(txCharPending), .beginBreakReq(beginBreakReq),
    .rxEnabled(), .txEnabled(txEnabled), .startTimeoutCmd(startTimeoutCmd), .timeoutValue(),
    .rxDmaEnd(dmaLv[0]), .txDmaEnd(dmaLv[1]), .txDmaBufferDrained(dmaLv[2]),
    .rxDmaBufferFull(dmaLv[3]), .modemPins(pins), .irq(irq));
  usr_engine_model i_usr_engine_model (.ref_clk(ref_clk), .sys_rst(sys_rst), .stall(stall),
    .txCharPending(txCharPending), .beginBreakReq(beginBreakReq), .txShiftLoad(txShiftLoad),
    .txShiftBusy(txShiftBusy), .breakStarted(breakStarted));
  // One APB transfer, held until pready is seen
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    // Only the watchdog ends a wait for pready
    do begin
      @(posedge ref_clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    nTests++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic stbit(input int b, input logic x);
    xfer(1'b0, usr_pkg::OFS_STATUS, 32'h0);
    chk("status bit", {31'h0, rd[b]}, {31'h0, x});
  endtask
  task automatic pulse(input int i);
    @(posedge ref_clk);
    evts[i] <= 1'b1;
    @(posedge ref_clk);
    evts[i] <= 1'b0;
  endtask
  task automatic drain;
    rd = 32'h0;
    for (n = 0; n < 20 && rd[9] !== 1'b1; n++) xfer(1'b0, usr_pkg::OFS_STATUS, 32'h0);
    chk("tx drained", {31'h0, rd[9]}, 32'h1);
  endtask
  // Expected modem part of the status word
  function automatic logic [31:0] modem_word(input logic [3:0] now, input logic [3:0] was);
    return {8'h00, now, now ^ was, 16'h0};
  endfunction
  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", nTests, mismatches);
    if (mismatches == 0 && nTests > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // Watchdog
  initial begin
    repeat (20000) @(posedge ref_clk);
    mismatches++;
    print_verdict;
  end
  // Main sequence
  initial begin
    seed = 53880;
    repeat (10) @(posedge ref_clk);
    sys_rst <= 1'b0;
    xfer(1'b0, usr_pkg::OFS_IRQ_MASK, 32'h0);
    chk("mask reset", rd, 32'h0);
    xfer(1'b1, usr_pkg::OFS_IRQ_EN, 32'hffffffff);
    xfer(1'b0, usr_pkg::OFS_IRQ_MASK, 32'h0);
    e = usr_pkg::MASK_VALID;
    chk("mask all", rd, e);
    repeat (4) begin
      r = $random(seed);
      e = e & ~r;
      xfer(1'b1, usr_pkg::OFS_IRQ_DIS, r);
      xfer(1'b0, usr_pkg::OFS_IRQ_MASK, 32'h0);
      chk("mask after disable", rd, e);
    end
    xfer(1'b1, usr_pkg::OFS_IRQ_DIS, 32'hffffffff);
    xfer(1'b1, usr_pkg::OFS_COMMAND, 32'h50);
    stbit(1, 1'b1);
    stbit(9, 1'b1);
    xfer(1'b1, usr_pkg::OFS_TIMEOUT, 32'h5);
    xfer(1'b0, usr_pkg::OFS_TIMEOUT, 32'h0);
    chk("timeout value", rd, 32'h5);
    for (int i = 0; i < 7; i++) begin
      pulse(i);
      stbit(bitOf[i], 1'b1);
      xfer(1'b1, usr_pkg::OFS_COMMAND, 32'h1 << clrOf[i]);
      stbit(bitOf[i], 1'b0);
    end
    for (int i = 0; i < 4; i++) pulse(i);
    xfer(1'b1, usr_pkg::OFS_COMMAND, 32'h100);
    xfer(1'b0, usr_pkg::OFS_STATUS, 32'h0);
    chk("errors cleared", rd & 32'he4, 32'h0);
    xfer(1'b1, usr_pkg::OFS_TIMEOUT, 32'h0);
    pulse(4);
    stbit(8, 1'b0);
    repeat (4) begin
      dmaLv <= 4'($random(seed));
      xfer(1'b0, usr_pkg::OFS_STATUS, 32'h0);
      chk("dma images", {28'h0, rd[12:11], rd[4:3]}, {28'h0, dmaLv});
    end
    rxChar <= 9'($random(seed));
    pulse(7);
    stbit(0, 1'b1);
    xfer(1'b0, usr_pkg::OFS_RX_HOLD, 32'h0);
    chk("rx char", rd, {23'h0, rxChar});
    stbit(0, 1'b0);
    pulse(7);
    xfer(1'b1, usr_pkg::OFS_COMMAND, 32'h20);
    stbit(0, 1'b0);
    xfer(1'b1, usr_pkg::OFS_COMMAND, 32'h10);
    stbit(0, 1'b1);
    stall <= 1'b1;
    xfer(1'b1, usr_pkg::OFS_TX_HOLD, $random(seed));
    stbit(1, 1'b0);
    stbit(9, 1'b0);
    stall <= 1'b0;
    drain;
    stbit(1, 1'b1);
    stall <= 1'b1;
    xfer(1'b1, usr_pkg::OFS_COMMAND, 32'h200);
    stbit(1, 1'b0);
    stall <= 1'b0;
    drain;
    xfer(1'b1, usr_pkg::OFS_COMMAND, 32'h80);
    stbit(1, 1'b0);
    stbit(9, 1'b0);
    xfer(1'b1, usr_pkg::OFS_COMMAND, 32'h40);
    stbit(1, 1'b1);
    repeat (3) begin
      np = 4'($random(seed));
      e = modem_word(np, pins);
      pins <= np;
      repeat (6) @(posedge ref_clk);
      xfer(1'b0, usr_pkg::OFS_STATUS, 32'h0);
      chk("modem bits", rd & 32'hffffc000, e);
      xfer(1'b0, usr_pkg::OFS_STATUS, 32'h0);
      chk("change flags", {28'h0, rd[19:16]}, 32'h0);
    end
    pulse(0);
    xfer(1'b1, usr_pkg::OFS_IRQ_EN, 32'h20);
    repeat (3) @(posedge ref_clk);
    chk("irq on", {31'h0, irq}, 32'h1);
    xfer(1'b1, usr_pkg::OFS_COMMAND, 32'h100);
    repeat (3) @(posedge ref_clk);
    chk("irq off", {31'h0, irq}, 32'h0);
    xfer(1'b0, 8'h3c, 32'h0);
    chk("unmapped", {rd[30:0], err}, 32'h1);
    xfer(1'b0, usr_pkg::OFS_LINK, 32'h0);
    chk("link enables", rd, 32'h3);
    print_verdict;
  end
endmodule
`default_nettype wire

// [usr_status_regs_properties.sv]
/* Checker for the status, mask and holding registers.
   Assumes it is bound to usr_status_regs, ports joined by name. */
`timescale 1ns/1ps
`default_nettype none
module usr_status_regs_properties (
  input wire logic                        ref_clk,         // Clock
  input wire logic                        sys_rst,         // Sync reset
  input wire logic                        psel,            // APB select
  input wire logic                        penable,         // APB access
  input wire logic                        pwrite,          // APB write
  input wire logic [7:0]                  paddr,           // APB address
  input wire logic [31:0]                 pwdata,          // APB write data
  input wire logic [31:0]                 prdata,          // APB read data
  input wire logic                        rxDmaEnd,        // Rx DMA end
  input wire logic                        txCharPending,   // Holding full
  input wire logic [usr_pkg::CHAR_W-1:0]  txCharField,     // Held char
  input wire logic                        beginBreakReq,   // Break pending
  input wire logic                        txEnabled,       // Tx on
  input wire logic                        startTimeoutCmd, // Timeout pulse
  input wire logic                        irq              // Interrupt
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  logic acc;
  logic rdSt;
  logic wrCmd;
  // Decoded access phases
  assign acc   = psel && penable;
  assign rdSt  = acc && !pwrite && paddr == usr_pkg::OFS_STATUS;
  assign wrCmd = acc && pwrite && paddr == usr_pkg::OFS_COMMAND;
  a_dma_end_image: assert property (rdSt |-> prdata[3] == $past(rxDmaEnd))
    else $error("rx dma end image wrong");
  a_tx_free_image: assert property (rdSt |->
    prdata[1] == $past(txEnabled && !txCharPending && !beginBreakReq))
    else $error("tx free image wrong");
  a_mask_reserved: assert property (acc && !pwrite && paddr == usr_pkg::OFS_IRQ_MASK |->
    (prdata & ~usr_pkg::MASK_VALID) == 32'h00000000)
    else $error("mask reserved bits set");
  a_rx_upper_zero: assert property (acc && !pwrite && paddr == usr_pkg::OFS_RX_HOLD |->
    prdata[31:9] == 23'h000000)
    else $error("rx holding upper bits set");
  a_hold_load: assert property (acc && pwrite && paddr == usr_pkg::OFS_TX_HOLD |=>
    txCharPending && txCharField == $past(pwdata[8:0]))
    else $error("tx holding not loaded");
  a_tx_enable_cmd: assert property (wrCmd && pwdata[6] && !pwdata[7] |=> txEnabled)
    else $error("tx not enabled");
  a_irq_disable_all: assert property (acc && pwrite && paddr == usr_pkg::OFS_IRQ_DIS &&
    pwdata == 32'hffffffff |-> ##2 !irq)
    else $error("irq after full disable");
  a_tmo_pulse: assert property (wrCmd && pwdata[11] |=> startTimeoutCmd ##1 !startTimeoutCmd)
    else $error("timeout start pulse wrong");
  c_rx_ready: cover property (rdSt && prdata[0]);
  c_irq: cover property (irq);
  c_break: cover property (wrCmd && pwdata[9]);
endmodule
`default_nettype wire
